//--- design/rorr_pkg.sv
// How it works
// - override bit 0 of 0x02 selects register power-down, else the pin governs
// - bit 3 of 0x06 enables register control of channels in slave mode
// - in slave mode, swing, de-emphasis and boost writes take effect only while enable bit is set
// - writing bit 6 of 0x07 returns all registers to defaults, bit self-clears
// - writing bit 5 of 0x07 resets the master state machine, bit self-clears
// - bit 6 of 0x08 selects register threshold, else the pin sets it
// - bit 3 of 0x08 selects register receiver-detect, else the pin selects it
// - per-channel power-down register, one bit per channel, 1 powers down
// - receiver-detect code 00 is high impedance, 11 is fixed 50 ohm termination
package rorr_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] ADDR_CHAN_PD = 8'h01;
    localparam logic [7:0] ADDR_PD_OVR = 8'h02;
    localparam logic [7:0] ADDR_SPARE_A = 8'h03;
    localparam logic [7:0] ADDR_SPARE_B = 8'h04;
    localparam logic [7:0] ADDR_SPARE_C = 8'h05;
    localparam logic [7:0] ADDR_SLAVE_CTRL = 8'h06;
    localparam logic [7:0] ADDR_SOFT_RST = 8'h07;
    localparam logic [7:0] ADDR_PIN_OVR = 8'h08;
    // ==========================================
    // reset values
    localparam logic [7:0] RST_CHAN_PD = 8'h00;
    localparam logic [7:0] RST_PD_OVR = 8'h00;
    localparam logic [7:0] RST_SPARE = 8'h00;
    localparam logic [7:0] RST_SLAVE_CTRL = 8'h10;
    localparam logic [7:0] RST_SOFT_RST = 8'h01;
    localparam logic [7:0] RST_PIN_OVR = 8'h00;
    // ==========================================
    // field positions
    localparam int BIT_PD_OVR = 0;
    localparam int BIT_REG_EN = 3;
    localparam int BIT_RST_REGS = 6;
    localparam int BIT_RST_MASTER = 5;
    localparam int BIT_SDTH_OVR = 6;
    localparam int BIT_RX_DETECT_OVR = 3;
    // soft reset register keeps only these bits; the two reset bits self-clear
    localparam logic [7:0] SOFT_RST_KEEP = 8'h9f;
    // receiver-detect codes
    localparam logic [1:0] RX_DETECT_HIZ = 2'h0;
    localparam logic [1:0] RX_DETECT_FIXED50 = 2'h3;

    typedef struct packed {
        logic [7:0] chan_pd;
        logic [7:0] pd_ovr;
        logic [7:0] spare_a;
        logic [7:0] spare_b;
        logic [7:0] spare_c;
        logic [7:0] slave_ctrl;
        logic [7:0] soft_rst;
        logic [7:0] pin_ovr;
    } rorr_regs_t;

    typedef struct packed {
        logic [7:0] swing;
        logic [7:0] deemph;
        logic [7:0] boost;
    } rorr_chan_cfg_t;
endpackage

//--- design/rorr_regs.sv
`timescale 1ns/1ps
module rorr_regs
    import rorr_pkg::*;
#(
    parameter int NUM_CH = 8
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // register port from the smbus slave
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    // channel settings write port
    input wire logic cfg_wr_in,
    input wire logic [2:0] cfg_ch_in,
    input wire rorr_chan_cfg_t cfg_in,
    // device pins
    input wire logic [NUM_CH-1:0] pin_power_down_in,
    input wire logic [1:0] pin_sd_threshold_in,
    input wire logic [1:0] pin_rx_detect_in,
    input wire logic slave_mode_in,
    // register-side values of neighbouring controls
    input wire logic [1:0] reg_sd_threshold_in,
    input wire logic [2*NUM_CH-1:0] reg_rx_detect_in,
    // effective controls
    output logic [NUM_CH-1:0] channel_power_down_out,
    output logic [1:0] signal_detect_threshold_out,
    output logic [2*NUM_CH-1:0] receiver_detect_select_out,
    output logic [NUM_CH-1:0] rx_hiz_out,
    output logic [NUM_CH-1:0] rx_term50_out,
    output rorr_chan_cfg_t [NUM_CH-1:0] chan_cfg_out,
    output logic master_reset_out
);
    // ==========================================
    // pin synchronisers
    logic [NUM_CH+3:0] pin_s1_q, pin_s2_q, pin_s1_d;
    assign pin_s1_d = {pin_power_down_in, pin_sd_threshold_in, pin_rx_detect_in};
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s1_q;
        end
    end
    logic [NUM_CH-1:0] pin_pd_s;
    logic [1:0] pin_sd_s, pin_rx_s;
    assign pin_pd_s = pin_s2_q[NUM_CH+3:4];
    assign pin_sd_s = pin_s2_q[3:2];
    assign pin_rx_s = pin_s2_q[1:0];

    // ==========================================
    // register bank
    rorr_regs_t regs_q, regs_d;
    logic mrst_q, mrst_d;
    logic sw_rst;
    assign sw_rst = wr_en_in && addr_in == ADDR_SOFT_RST && wdata_in[BIT_RST_REGS];

    always_comb
    begin
        regs_d = regs_q;
        mrst_d = 1'b0;
        if (sw_rst)
        begin
            // all bank registers back to defaults in one cycle
            regs_d.chan_pd = RST_CHAN_PD;
            regs_d.pd_ovr = RST_PD_OVR;
            regs_d.spare_a = RST_SPARE;
            regs_d.spare_b = RST_SPARE;
            regs_d.spare_c = RST_SPARE;
            regs_d.slave_ctrl = RST_SLAVE_CTRL;
            regs_d.soft_rst = RST_SOFT_RST;
            regs_d.pin_ovr = RST_PIN_OVR;
        end
        else if (wr_en_in)
        begin
            case (addr_in)
                ADDR_CHAN_PD: regs_d.chan_pd = wdata_in;
                ADDR_PD_OVR: regs_d.pd_ovr = wdata_in;
                ADDR_SPARE_A: regs_d.spare_a = wdata_in;
                ADDR_SPARE_B: regs_d.spare_b = wdata_in;
                ADDR_SPARE_C: regs_d.spare_c = wdata_in;
                ADDR_SLAVE_CTRL: regs_d.slave_ctrl = wdata_in;
                // reset bits are never stored, so they read back zero
                ADDR_SOFT_RST: regs_d.soft_rst = wdata_in & SOFT_RST_KEEP;
                ADDR_PIN_OVR: regs_d.pin_ovr = wdata_in;
                default: regs_d = regs_q;
            endcase
        end
        if (wr_en_in && addr_in == ADDR_SOFT_RST && wdata_in[BIT_RST_MASTER])
        begin
            mrst_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            regs_q <= {RST_CHAN_PD, RST_PD_OVR, RST_SPARE, RST_SPARE, RST_SPARE,
                       RST_SLAVE_CTRL, RST_SOFT_RST, RST_PIN_OVR};
            mrst_q <= 1'b0;
        end
        else
        begin
            regs_q <= regs_d;
            mrst_q <= mrst_d;
        end
    end
    assign master_reset_out = mrst_q;

    // ==========================================
    // read mux, unmapped offsets read zero
    logic [7:0] rdata_d, rdata_q;
    always_comb
    begin
        case (addr_in)
            ADDR_CHAN_PD: rdata_d = regs_q.chan_pd;
            ADDR_PD_OVR: rdata_d = regs_q.pd_ovr;
            ADDR_SPARE_A: rdata_d = regs_q.spare_a;
            ADDR_SPARE_B: rdata_d = regs_q.spare_b;
            ADDR_SPARE_C: rdata_d = regs_q.spare_c;
            ADDR_SLAVE_CTRL: rdata_d = regs_q.slave_ctrl;
            ADDR_SOFT_RST: rdata_d = regs_q.soft_rst;
            ADDR_PIN_OVR: rdata_d = regs_q.pin_ovr;
            default: rdata_d = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end
    assign rdata_out = rdata_q;

    // ==========================================
    // channel settings, gated by the slave enable bit
    rorr_chan_cfg_t [NUM_CH-1:0] cfg_q, cfg_d;
    logic cfg_allow;
    assign cfg_allow = !slave_mode_in || regs_q.slave_ctrl[BIT_REG_EN];
    always_comb
    begin
        cfg_d = cfg_q;
        if (cfg_wr_in && cfg_allow)
            cfg_d[cfg_ch_in] = cfg_in;
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cfg_q <= '0;
        else
            cfg_q <= cfg_d;
    end
    assign chan_cfg_out = cfg_q;

    // ==========================================
    // pin versus register selection
    // registered: the controls settle one cycle after the register or synced pin
    logic [NUM_CH-1:0] pd_eff_q, pd_eff_d;
    logic [1:0] sd_eff_q, sd_eff_d;
    logic [2*NUM_CH-1:0] rx_sel_q, rx_sel_d;
    logic [NUM_CH-1:0] hiz_q, hiz_d, term50_q, term50_d;
    always_comb
    begin
        pd_eff_d = regs_q.pd_ovr[BIT_PD_OVR] ? regs_q.chan_pd : pin_pd_s;
        sd_eff_d = regs_q.pin_ovr[BIT_SDTH_OVR] ? reg_sd_threshold_in : pin_sd_s;
    end
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [1:0] sel;
            assign sel = regs_q.pin_ovr[BIT_RX_DETECT_OVR] ?
                reg_rx_detect_in[2*g +: 2] : pin_rx_s;
            assign rx_sel_d[2*g +: 2] = sel;
            assign hiz_d[g] = sel == RX_DETECT_HIZ;
            assign term50_d[g] = sel == RX_DETECT_FIXED50;
        end
    endgenerate
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pd_eff_q <= '0;
            sd_eff_q <= '0;
            rx_sel_q <= '0;
            // synced pins are zero in reset, which decodes as high impedance
            hiz_q <= '1;
            term50_q <= '0;
        end
        else
        begin
            pd_eff_q <= pd_eff_d;
            sd_eff_q <= sd_eff_d;
            rx_sel_q <= rx_sel_d;
            hiz_q <= hiz_d;
            term50_q <= term50_d;
        end
    end
    assign channel_power_down_out = pd_eff_q;
    assign signal_detect_threshold_out = sd_eff_q;
    assign receiver_detect_select_out = rx_sel_q;
    assign rx_hiz_out = hiz_q;
    assign rx_term50_out = term50_q;

    // ==========================================
    // checks
    a_pd_override: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        regs_q.pd_ovr[BIT_PD_OVR] |=> channel_power_down_out == $past(regs_q.chan_pd))
        else $error("power-down not taken from register");
    a_soft_reset_defaults: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        sw_rst |=> regs_q.slave_ctrl == RST_SLAVE_CTRL && regs_q.soft_rst == RST_SOFT_RST)
        else $error("soft reset did not restore defaults");
    a_reset_bits_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        regs_q.soft_rst[BIT_RST_REGS] == 1'b0 && regs_q.soft_rst[BIT_RST_MASTER] == 1'b0)
        else $error("reset bit stayed set");
    a_master_pulse: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        master_reset_out |=> !master_reset_out || $past(mrst_d))
        else $error("master reset did not self-clear");
    a_cfg_gated: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        slave_mode_in && !regs_q.slave_ctrl[BIT_REG_EN] |=> $stable(cfg_q))
        else $error("channel setting changed while disabled");
    a_sdth_select: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        !regs_q.pin_ovr[BIT_SDTH_OVR] |=> signal_detect_threshold_out == $past(pin_sd_s))
        else $error("threshold not from pin");
    a_rx_detect_select: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        !regs_q.pin_ovr[BIT_RX_DETECT_OVR] |=>
            receiver_detect_select_out[1:0] == $past(pin_rx_s))
        else $error("receiver detect not from pin");
    a_chan_pd_write: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        wr_en_in && addr_in == ADDR_CHAN_PD && !sw_rst |=> regs_q.chan_pd == $past(wdata_in))
        else $error("power-down register not written");
    a_enable_cfg: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        cfg_wr_in && regs_q.slave_ctrl[BIT_REG_EN] |=>
            cfg_q[$past(cfg_ch_in)] == $past(cfg_in))
        else $error("enabled setting write lost");
    a_term_code: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        rx_hiz_out[0] |-> !rx_term50_out[0] && receiver_detect_select_out[1:0] == RX_DETECT_HIZ)
        else $error("receiver detect decode wrong");
endmodule // rorr_regs

//--- sim/rorr_host_model.sv
`timescale 1ns/1ps
module rorr_host_model
    import rorr_pkg::*;
(
    // clock
    input wire logic ref_clk_in,
    // register port
    output logic wr_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in
);
    initial
    begin
        wr_en_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // ==========================================
    // single byte write, strobe held one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge ref_clk_in);
        wr_en_out <= 1'b0;
        // released data is inverted, so a stale byte is never mistaken for a write
        wdata_out <= ~d;
    endtask
    // read data is registered, so it is taken two edges after the offset
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr_out <= a;
        repeat (2) @(posedge ref_clk_in);
        d = rdata_in;
    endtask
endmodule // rorr_host_model

//--- sim/repeater_override_reset_regs_tb.sv
`timescale 1ns/1ps
module repeater_override_reset_regs_tb;
    import rorr_pkg::*;
    logic ref_clk_in, arst_n_in, wr_en, cfg_wr, slave_mode, mrst;
    logic [7:0] addr, wdata, rdata, pin_pd, pd_out, hiz, t50, v;
    logic [2:0] cfg_ch;
    logic [1:0] pin_sd, pin_rx, reg_sd, sd_out;
    logic [15:0] reg_rx, rx_out;
    rorr_chan_cfg_t cfg;
    rorr_chan_cfg_t [7:0] cfg_out;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] dflt [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01, 8'h00};

    rorr_host_model host (.ref_clk_in(ref_clk_in), .wr_en_out(wr_en), .addr_out(addr),
        .wdata_out(wdata), .rdata_in(rdata));
    rorr_regs #(.NUM_CH(8)) i_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .wr_en_in(wr_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
        .cfg_wr_in(cfg_wr), .cfg_ch_in(cfg_ch), .cfg_in(cfg), .pin_power_down_in(pin_pd),
        .pin_sd_threshold_in(pin_sd), .pin_rx_detect_in(pin_rx), .slave_mode_in(slave_mode),
        .reg_sd_threshold_in(reg_sd), .reg_rx_detect_in(reg_rx),
        .channel_power_down_out(pd_out),
        .signal_detect_threshold_out(sd_out), .receiver_detect_select_out(rx_out),
        .rx_hiz_out(hiz), .rx_term50_out(t50), .chan_cfg_out(cfg_out),
        .master_reset_out(mrst));

    // ==========================================
    // clock, timeout, reporting
    initial
    begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_defaults;
        for (int i = 0; i < 9; i++)
        begin
            host.rd(i[7:0], v);
            chk("reset value", dflt[i], v);
        end
        host.wr(8'h20, 8'h5a);
        host.rd(8'h20, v);
        chk("unmapped", 8'h00, v);
        $display("test defaults done");
    endtask
    task automatic t_power_down;
        @(posedge ref_clk_in);
        pin_pd <= 8'ha5;
        host.wr(ADDR_CHAN_PD, 8'hff);
        repeat (3) @(negedge ref_clk_in);
        chk("pd by pin", 8'ha5, pd_out);
        host.wr(ADDR_PD_OVR, 8'h01);
        repeat (2) @(negedge ref_clk_in);
        chk("pd by reg", 8'hff, pd_out);
        host.wr(ADDR_CHAN_PD, 8'h00);
        repeat (2) @(negedge ref_clk_in);
        chk("pd all on", 8'h00, pd_out);
        $display("test power_down done");
    endtask
    task automatic t_pin_override;
        @(posedge ref_clk_in);
        pin_sd <= 2'h2;
        pin_rx <= RX_DETECT_HIZ;
        reg_sd <= 2'h1;
        reg_rx <= {8{RX_DETECT_FIXED50}};
        // two sync stages plus the output register
        repeat (4) @(negedge ref_clk_in);
        chk("sd by pin", 2'h2, sd_out);
        chk("rx by pin", 16'h0000, rx_out);
        chk("hiz", 8'hff, hiz);
        host.wr(ADDR_PIN_OVR, 8'h48);
        repeat (2) @(negedge ref_clk_in);
        chk("sd by reg", 2'h1, sd_out);
        chk("rx by reg", 16'hffff, rx_out);
        chk("term50", 8'hff, t50);
        chk("hiz off", 8'h00, hiz);
        $display("test pin_override done");
    endtask
    task automatic cfg_pulse;
        @(posedge ref_clk_in);
        cfg_wr <= 1'b1;
        @(posedge ref_clk_in);
        cfg_wr <= 1'b0;
        @(negedge ref_clk_in);
    endtask
    task automatic t_slave_cfg;
        @(posedge ref_clk_in);
        slave_mode <= 1'b1;
        cfg_ch <= 3'h2;
        cfg <= 24'h123456;
        cfg_pulse();
        chk("cfg refused", 24'h000000, cfg_out[2]);
        host.wr(ADDR_SLAVE_CTRL, 8'h18);
        cfg_pulse();
        chk("cfg taken", 24'h123456, cfg_out[2]);
        $display("test slave_cfg done");
    endtask
    task automatic t_soft_reset;
        host.wr(ADDR_PD_OVR, 8'h01);
        host.wr(ADDR_SOFT_RST, 8'h21);
        @(negedge ref_clk_in);
        chk("master pulse", 1'b1, mrst);
        @(negedge ref_clk_in);
        chk("master pulse end", 1'b0, mrst);
        host.rd(ADDR_SOFT_RST, v);
        chk("rst after master", 8'h01, v);
        host.rd(ADDR_PD_OVR, v);
        chk("ovr kept", 8'h01, v);
        host.wr(ADDR_SOFT_RST, 8'h41);
        host.rd(ADDR_PD_OVR, v);
        chk("ovr default", 8'h00, v);
        host.rd(ADDR_SLAVE_CTRL, v);
        chk("slave default", 8'h10, v);
        host.rd(ADDR_SOFT_RST, v);
        chk("rst after regs", 8'h01, v);
        $display("test soft_reset done");
    endtask

    initial
    begin
        arst_n_in = 1'b0;
        cfg_wr = 1'b0;
        cfg_ch = 3'h0;
        cfg = '0;
        slave_mode = 1'b0;
        pin_pd = 8'h00;
        pin_sd = 2'h0;
        pin_rx = 2'h0;
        reg_sd = 2'h0;
        reg_rx = 16'h0000;
        repeat (8) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        t_defaults();
        t_power_down();
        t_pin_override();
        t_slave_cfg();
        t_soft_reset();
        final_report();
    end
endmodule // repeater_override_reset_regs_tb
